// *** inc/ims_pkg.sv ***
// shared constants, register map and carrier types of the interleaved main store
// assumes a single 10 MHz clock and a synchronous active-high reset
package ims_pkg;

   localparam int unsigned DATA_W   = 60;
   localparam int unsigned CHK_W    = 8;
   localparam int unsigned ADDR_W   = 18;
   localparam int unsigned NBANK    = 16;
   localparam int unsigned BANK_W   = 4;
   localparam int unsigned IDX_W    = 14;
   localparam int unsigned MIN_WORDS = 131072;
   localparam int unsigned MAX_WORDS = 262144;
   localparam int unsigned WORDS_PER_BANK = MAX_WORDS / NBANK;
   localparam int unsigned PORTION_WORDS  = 65536;
   localparam logic [2:0]  MIN_PORTIONS   = 3'(MIN_WORDS / PORTION_WORDS);
   localparam logic [2:0]  MAX_PORTIONS   = 3'(MAX_WORDS / PORTION_WORDS);

   // times in picoseconds
   localparam int unsigned CLK_PS   = 100000;
   localparam int unsigned READ_PS  = 82500;
   localparam int unsigned WRITE_PS = 165000;
   localparam int unsigned XFER_PS  = 27500;
   localparam int unsigned READ_CYC  = (READ_PS + CLK_PS - 1) / CLK_PS;
   localparam int unsigned WRITE_CYC = (WRITE_PS + CLK_PS - 1) / CLK_PS;
   localparam int unsigned XFER_CYC  = (XFER_PS / CLK_PS) < 1 ? 1 : XFER_PS / CLK_PS;

   // register byte addresses
   localparam logic [31:0] REG_CTRL  = 32'h0000_0000;
   localparam logic [31:0] REG_STAT  = 32'h0000_0004;
   localparam logic [31:0] REG_EADDR = 32'h0000_0008;
   localparam logic [31:0] REG_SYN   = 32'h0000_000c;
   localparam logic [31:0] REG_CFG   = 32'h0000_0010;

   // field positions
   localparam int unsigned CTRL_CLRPAR_BIT = 8;
   localparam int unsigned STAT_SBE_BIT    = 0;
   localparam int unsigned STAT_PSW_BIT    = 1;
   localparam int unsigned STAT_LOCK_BIT   = 2;
   localparam int unsigned CFG_LOCK_BIT    = 3;
   localparam int unsigned CFG_SEL_LSB     = 4;

   typedef struct packed {
      logic nodbe;   // suppress double-error report
      logic nolog;   // inhibit single-error logging
      logic test;
      logic maint;
      logic par;     // byte parity instead of check bits
   } ims_ctrl_t;

   localparam ims_ctrl_t CTRL_RST = 5'h00;
   localparam logic [4:0] SW_RST  = 5'h00;

   typedef struct packed {
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ims_req_t;

   typedef struct packed {
      logic [CHK_W-1:0]  chk;
      logic [DATA_W-1:0] data;
   } ims_word_t;

endpackage

// *** verilog/ims_bank.sv ***
// one independent storage bank with its own cycle timer
// assumes the caller only starts it while busy_o is low
`timescale 1ns/10ps
module ims_bank (
   input  wire logic                    clk_i,   // system clock
   input  wire logic                    rst_i,   // sync reset
   input  wire logic                    go_i,    // start a cycle
   input  wire logic                    we_i,    // cycle is a write
   input  wire logic [ims_pkg::IDX_W-1:0] idx_i, // word within bank
   input  wire ims_pkg::ims_word_t      wword_i, // coded write word
   output logic                         busy_o,  // cycle in progress
   output ims_pkg::ims_word_t           rword_o  // coded read word
);
   ims_pkg::ims_word_t mem [ims_pkg::WORDS_PER_BANK];
   logic [2:0]         cnt;

   // storage has no reset; contents are undefined until written
   always_ff @(posedge clk_i)
   begin
      if (go_i && we_i)
         mem[idx_i] <= wword_i;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rword_o <= '0;
      else if (go_i && !we_i)
         rword_o <= mem[idx_i];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cnt <= 3'h0;
      else if (go_i)
         cnt <= we_i ? 3'(ims_pkg::WRITE_CYC - 1) : 3'(ims_pkg::READ_CYC - 1); // see [R4]
      else if (cnt != 3'h0)
         cnt <= cnt - 3'h1;
   end

   assign busy_o = (cnt != 3'h0);
endmodule

// *** verilog/ims_codec.sv ***
// check-bit and byte-parity coder for the 60-bit data word
// purely combinational; the caller registers what it needs
`timescale 1ns/10ps
module ims_codec (
   input  wire logic                      par_i,   // parity mode
   input  wire logic                      test_i,  // test mode
   input  wire logic [ims_pkg::DATA_W-1:0] wdata_i, // data to write
   input  wire ims_pkg::ims_word_t        rword_i, // word read back
   output logic [ims_pkg::CHK_W-1:0]      wchk_o,  // check bits to store
   output logic [ims_pkg::DATA_W-1:0]     rdata_o, // corrected data
   output logic [ims_pkg::CHK_W-1:0]      syn_o,   // syndrome
   output logic                           sbe_o,   // single error seen
   output logic                           dbe_o,   // double error seen
   output logic [ims_pkg::CHK_W-1:0]      pfail_o  // failing byte mask
);
   // codeword position of data bit k: the k-th position that is no power of two
   function automatic logic [6:0] pos(input int k);
      logic [6:0] r;
      int         n;
      r = 7'h00;
      n = 0;
      for (int p = 3; p < 68; p++)
         if ((p & (p - 1)) != 0)
         begin
            if (n == k)
               r = 7'(p);
            n++;
         end
      return r;
   endfunction

   function automatic logic [7:0] secded(input logic [59:0] d);
      logic [6:0] h;
      h = 7'h00;
      for (int k = 0; k < 60; k++)
         if (d[k])
            h ^= pos(k);
      return {^{d, h}, h};
   endfunction

   function automatic logic [7:0] bytepar(input logic [59:0] d);
      logic [7:0] p;
      p = 8'h00;
      for (int i = 0; i < 60; i++)
         p[i / 8] ^= d[i];
      return p;
   endfunction

   logic [6:0] s7;
   logic       ov;
   logic [7:0] recode;

   always_comb
   begin
      if (par_i)
         wchk_o = test_i ? ~bytepar(wdata_i) : bytepar(wdata_i);  // see [R19] see [R11]
      else
         wchk_o = test_i ? 8'h00 : secded(wdata_i);               // see [R18] see [R2]
   end

   always_comb
   begin
      recode  = secded(rword_i.data);
      s7      = rword_i.chk[6:0] ^ recode[6:0];
      ov      = !par_i && ^{rword_i.data, rword_i.chk};
      syn_o   = {ov, s7};
      sbe_o   = ov;                                     // see [R9]
      dbe_o   = !par_i && !ov && (s7 != 7'h00);
      pfail_o = par_i ? (bytepar(rword_i.data) ^ rword_i.chk) : 8'h00;
      for (int k = 0; k < 60; k++)
         rdata_o[k] = rword_i.data[k] ^ (ov && (s7 == pos(k)));  // see [R9] see [R16]
   end
endmodule

// *** verilog/ims_main_store.sv ***
// interleaved main store: 16 phased banks, check-bit or parity coding,
// error capture and a classic wishbone control port
// assumes the processor holds a request until req_ready_o is seen high
//
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/10ps

// Notes on behaviour
// [R1] word is 60 data plus 8 check
// [R2] code on write, check on read
// [R3] banks run cycles independently
// [R4] read one cycle, write two cycles
// [R5] low address bits pick the bank
// [R6] sequential references accepted every cycle
// [R7] busy bank holds off new reference
// [R8] size 131072 up to 262144 words
// [R9] single errors corrected and logged
// [R10] double error flags, jumps, captures
// [R11] parity mode checks reads only
// [R12] parity mode records every read address (here only in-range reads while not locked)
// [R13] parity error locks until clear
// [R14] parity error flags and jumps
// [R15] errors while locked are ignored
// [R16] same latency in either mode
// [R17] maintenance reports single like double
// [R18] test mode zeroes check bits
// [R19] test mode inverts parity bits
// [R20] inhibit bit stops single logging
// [R21] switches lock out one portion
// [R22] suppressed double error is silent
module ims_main_store (
   input  wire logic                       clk_i,       // 10 MHz clock
   input  wire logic                       rst_i,       // sync reset
   input  wire logic                       wb_cyc_i,    // bus cycle
   input  wire logic                       wb_stb_i,    // bus strobe
   input  wire logic                       wb_we_i,     // bus write
   input  wire logic [31:0]                wb_adr_i,    // byte address
   input  wire logic [3:0]                 wb_sel_i,    // byte lanes
   input  wire logic [31:0]                wb_dat_i,    // write data
   output logic [31:0]                     wb_dat_o,    // read data
   output logic                            wb_ack_o,    // bus ack
   input  wire logic                       req_valid_i, // reference valid
   input  wire ims_pkg::ims_req_t          req_i,       // reference
   output logic                            req_ready_o, // reference taken
   output logic                            rsp_valid_o, // read data valid
   output logic [ims_pkg::DATA_W-1:0]      rsp_data_o,  // read data
   output logic                            psw_err_o,   // status word bit 10
   input  wire logic                       psw_clr_i,   // clears psw_err_o
   output logic                            exch_req_o,  // exchange jump pulse
   input  wire logic [1:0]                 size_sw_i,   // installed size switch
   input  wire logic                       lock_en_i,   // lockout switch
   input  wire logic [1:0]                 lock_sel_i   // portion to lock out
);
   localparam int unsigned NB = ims_pkg::NBANK;
   localparam int unsigned BW = ims_pkg::BANK_W;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   ims_pkg::ims_ctrl_t  ctrl;
   logic [4:0]          sw1, sw2, sw3, sw;
   logic [2:0]          base, eff;
   logic                lockout;
   logic                acc, oor;
   logic [BW-1:0]       bank;
   logic [2:0]          pp;
   logic [NB-1:0]       busy, go;
   ims_pkg::ims_word_t  rwords [NB];
   ims_pkg::ims_word_t  rsel;
   logic [7:0]          wchk, syn, pfail;
   logic [59:0]         cdata;
   logic                single_bit_error, dbe;
   logic                s1_v, s1_oor;
   logic [BW-1:0]       s1_bank;
   logic [17:0]         s1_addr;
   logic                chk_ok, perr, report, log_sbe, cap;
   logic                lock, sbe_flag, clr_par;
   logic [17:0]         err_addr;
   logic [7:0]          err_syn;
   logic                bus_req, wr_ctrl, wr_stat;
   logic [31:0]         next_dat;

   // switches are slow and settle long before use; a new value is taken
   // only once the last two stages agree
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sw1 <= ims_pkg::SW_RST;
         sw2 <= ims_pkg::SW_RST;
         sw3 <= ims_pkg::SW_RST;
         sw  <= ims_pkg::SW_RST;
      end
      else
      begin
         sw1 <= {size_sw_i, lock_en_i, lock_sel_i};
         sw2 <= sw1;
         sw3 <= sw2;
         if (sw2 == sw3)
            sw <= sw3;
      end
   end

   always_comb
   begin
      case (sw[4:3])                                        // see [R8]
         2'h0:    base = ims_pkg::MIN_PORTIONS;
         2'h1:    base = ims_pkg::MIN_PORTIONS + 3'h1;
         default: base = ims_pkg::MAX_PORTIONS;
      endcase
      // one portion at a time, never below the smallest size
      lockout = sw[2] && (base > ims_pkg::MIN_PORTIONS) && ({1'b0, sw[1:0]} < base); // see [R21]
      eff     = base - {2'h0, lockout};
   end

   // logical portion is remapped past the locked-out one so the address
   // space stays contiguous
   function automatic logic [2:0] remap(input logic [1:0] lp, input logic lo,
                                        input logic [1:0] ls);
      return (lo && lp >= ls) ? {1'b0, lp} + 3'h1 : {1'b0, lp};
   endfunction

   assign bank        = req_i.addr[BW-1:0];                 // see [R5]
   assign pp          = remap(req_i.addr[17:16], lockout, sw[1:0]);  // see [R21]
   assign oor         = ({1'b0, req_i.addr[17:16]} >= eff);
   assign req_ready_o = !busy[bank];                        // see [R7] see [R6]
   assign acc         = req_valid_i && req_ready_o;

   ims_codec u_codec (
      .par_i   (ctrl.par),
      .test_i  (ctrl.test),
      .wdata_i (req_i.wdata),
      .rword_i (rsel),
      .wchk_o  (wchk),
      .rdata_o (cdata),
      .syn_o   (syn),
      .sbe_o   (single_bit_error),
      .dbe_o   (dbe),
      .pfail_o (pfail)
   );

   for (genvar b = 0; b < NB; b++)
   begin : g_bank
      assign go[b] = acc && !oor && (bank == BW'(b));       // see [R3]
      ims_bank u_bank (
         .clk_i   (clk_i),
         .rst_i   (rst_i),
         .go_i    (go[b]),
         .we_i    (req_i.we),
         .idx_i   ({pp[1:0], req_i.addr[15:BW]}),
         .wword_i ({wchk, req_i.wdata}),                    // see [R1] see [R2]
         .busy_o  (busy[b]),
         .rword_o (rwords[b])
      );
   end

   assign rsel = rwords[s1_bank];

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_v    <= 1'b0;
         s1_oor  <= 1'b0;
         s1_bank <= '0;
         s1_addr <= 18'h00000;
      end
      else
      begin
         s1_v    <= acc && !req_i.we;                       // see [R11]
         s1_oor  <= oor;
         s1_bank <= bank;
         s1_addr <= req_i.addr;
      end
   end

   // read events, all decided in the cycle the bank word is presented
   always_comb
   begin
      chk_ok  = s1_v && !s1_oor;
      perr    = chk_ok && ctrl.par && (pfail != 8'h00);
      report  = ctrl.par ? (perr && !lock)                  // see [R14] see [R15]
                         : chk_ok && ((dbe && !ctrl.nodbe) || (single_bit_error && ctrl.maint)); // see [R10] see [R17] see [R22]
      log_sbe = chk_ok && !ctrl.par && single_bit_error && !ctrl.nolog;  // see [R20]
      cap     = ctrl.par ? (chk_ok && !lock) : (report || log_sbe);  // see [R12]
   end

   // out-of-range reads answer all ones without touching a bank
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rsp_valid_o <= 1'b0;
         rsp_data_o  <= '0;
         exch_req_o  <= 1'b0;
      end
      else
      begin
         rsp_valid_o <= s1_v;                               // see [R16]
         rsp_data_o  <= s1_oor ? '1 : cdata;                // see [R9]
         exch_req_o  <= report;                             // see [R10] see [R14]
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         err_addr <= 18'h00000;
         err_syn  <= 8'h00;
      end
      else if (cap)
      begin
         err_addr <= s1_addr;                               // see [R12] see [R10]
         if (ctrl.par)
            err_syn <= perr ? (rsel.chk & pfail) : err_syn; // see [R13]
         else
            err_syn <= syn;
      end
   end

   // set wins over every clear
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         lock      <= 1'b0;
         psw_err_o <= 1'b0;
         sbe_flag  <= 1'b0;
      end
      else
      begin
         if (ctrl.par && report)
            lock <= 1'b1;                                   // see [R13]
         else if (clr_par)
            lock <= 1'b0;
         if (report)
            psw_err_o <= 1'b1;
         else if (psw_clr_i || (wr_stat && wb_dat_i[ims_pkg::STAT_PSW_BIT]))
            psw_err_o <= 1'b0;
         if (log_sbe)
            sbe_flag <= 1'b1;                               // see [R9]
         else if (wr_stat && wb_dat_i[ims_pkg::STAT_SBE_BIT])
            sbe_flag <= 1'b0;
      end
   end

   // wishbone slave: ack one cycle after the strobe, writes act on the ack edge
   assign bus_req = wb_cyc_i && wb_stb_i;
   assign wr_ctrl = bus_req && wb_we_i && wb_ack_o && (wb_adr_i == ims_pkg::REG_CTRL);
   assign wr_stat = bus_req && wb_we_i && wb_ack_o && (wb_adr_i == ims_pkg::REG_STAT)
                    && wb_sel_i[0];
   assign clr_par = wr_ctrl && wb_sel_i[1] && wb_dat_i[ims_pkg::CTRL_CLRPAR_BIT];  // see [R13]

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ctrl <= ims_pkg::CTRL_RST;
      else if (wr_ctrl && wb_sel_i[0])
         ctrl <= wb_dat_i[4:0];
   end

   always_comb
   begin
      case (wb_adr_i)
         ims_pkg::REG_CTRL:  next_dat = {27'h0, ctrl};
         ims_pkg::REG_STAT:  next_dat = {29'h0, lock, psw_err_o, sbe_flag};
         ims_pkg::REG_EADDR: next_dat = {14'h0, err_addr};
         ims_pkg::REG_SYN:   next_dat = {24'h0, err_syn};
         ims_pkg::REG_CFG:   next_dat = {26'h0, sw[1:0], lockout, eff};
         default:            next_dat = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= bus_req && !wb_ack_o;
         wb_dat_o <= (bus_req && !wb_ack_o && !wb_we_i) ? next_dat : wb_dat_o;
      end
   end

   // checks
   property p_write_holds;
      (acc && req_i.we && !oor) ##1 (req_valid_i && req_i.addr[3:0] == $past(bank))
         |-> !req_ready_o;
   endproperty
   a_write_holds: assert property (p_write_holds) else $error("bank free during write"); // see [R7]

   property p_other_bank;
      (acc && req_i.we) ##1 (req_i.addr[3:0] != $past(bank)) |-> req_ready_o;
   endproperty
   a_other_bank: assert property (p_other_bank) else $error("idle bank held off"); // see [R3]

   property p_read_lat;
      acc && !req_i.we |-> ##2 rsp_valid_o;
   endproperty
   a_read_lat: assert property (p_read_lat) else $error("read answer late"); // see [R4]

   property p_seq_reads;
      (acc && !req_i.we) ##1 (req_valid_i && !req_i.we) |-> req_ready_o;
   endproperty
   a_seq_reads: assert property (p_seq_reads) else $error("read stream stalled"); // see [R6]

   property p_par_lock;
      perr && !lock |=> lock && exch_req_o && psw_err_o;
   endproperty
   a_par_lock: assert property (p_par_lock) else $error("parity error not locked"); // see [R14]

   property p_locked_quiet;
      ctrl.par && lock && !clr_par && chk_ok |=> $stable(err_addr) && $stable(err_syn)
         && !exch_req_o;
   endproperty
   a_locked_quiet: assert property (p_locked_quiet) else $error("capture while locked"); // see [R15]

   property p_par_addr;
      ctrl.par && chk_ok && !lock |=> err_addr == $past(s1_addr);
   endproperty
   a_par_addr: assert property (p_par_addr) else $error("read address not recorded"); // see [R12]

   property p_dbe;
      chk_ok && !ctrl.par && dbe && !ctrl.nodbe |=> exch_req_o && psw_err_o
         && err_syn == $past(syn);
   endproperty
   a_dbe: assert property (p_dbe) else $error("double error not reported"); // see [R10]

   property p_dbe_quiet;
      chk_ok && !ctrl.par && dbe && ctrl.nodbe |=> !exch_req_o;
   endproperty
   a_dbe_quiet: assert property (p_dbe_quiet) else $error("suppressed error reported"); // see [R22]

   property p_maint;
      chk_ok && !ctrl.par && single_bit_error && ctrl.maint |=> exch_req_o;
   endproperty
   a_maint: assert property (p_maint) else $error("maintenance single not reported"); // see [R17]

   property p_nolog;
      chk_ok && single_bit_error && ctrl.nolog && !sbe_flag |=> !sbe_flag;
   endproperty
   a_nolog: assert property (p_nolog) else $error("single error logged"); // see [R20]

   property p_test_zero;
      acc && req_i.we && ctrl.test && !ctrl.par |-> wchk == 8'h00;
   endproperty
   a_test_zero: assert property (p_test_zero) else $error("test check bits not zero"); // see [R18]

   c_sbe:    cover property (chk_ok && single_bit_error && !ctrl.par);
   c_dbe:    cover property (chk_ok && dbe && !ctrl.nodbe);
   c_plock:  cover property (perr && !lock);
   c_stream: cover property (acc && !req_i.we ##1 acc && !req_i.we);
endmodule

// *** sim/ims_cpu_model.sv ***
// processor side model: one reference at a time on the memory port
// assumes ready is combinational and judged at the rising edge
`timescale 1ns/10ps
module ims_cpu_model (
   input  wire logic         clk_i,       // system clock
   input  wire logic         req_ready_i, // reference taken
   output logic              req_valid_o, // reference valid
   output ims_pkg::ims_req_t req_o        // reference
);
   initial
   begin
      req_valid_o = 1'b0;
      req_o       = '0;
   end

   // gap 0 keeps valid up so the next call streams one per cycle
   task automatic issue(input logic we, input logic [17:0] a, input logic [59:0] d,
                        input int gap);
      req_o       <= '{we, a, d};
      req_valid_o <= 1'b1;
      do @(posedge clk_i); while (req_ready_i !== 1'b1);
      if (gap > 0)
      begin
         req_valid_o <= 1'b0;
         req_o       <= ~req_o;  // released lines do not keep the old value
         repeat (gap) @(posedge clk_i);
      end
   endtask
endmodule

// *** sim/ims_main_store_test.sv ***
// self-checking bench of the interleaved main store
// assumes the processor model beside it and a wishbone master below
`timescale 1ns/10ps
module ims_main_store_test;
   logic               clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [31:0]        wb_adr_i, wb_dat_i, wb_dat_o, q, r;
   logic [3:0]         wb_sel_i, pb;
   logic               req_valid_i, req_ready_o, rsp_valid_o, psw_err_o, psw_clr_i;
   logic               exch_req_o, lock_en_i, plock, pw;
   logic [1:0]         size_sw_i, lock_sel_i;
   logic [59:0]        rsp_data_o;
   ims_pkg::ims_req_t  req_i;
   ims_pkg::ims_ctrl_t ctrl;
   int                 n_mismatch, samples_checked, cyc_n, seed, n_port;
   logic [59:0]        mem [logic [17:0]];
   logic [1:0]         kind [logic [17:0]];
   int                 dq [$];
   logic [59:0]        xq [$];
   logic               eq [$];

   ims_main_store dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
      .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .psw_err_o(psw_err_o),
      .psw_clr_i(psw_clr_i), .exch_req_o(exch_req_o), .size_sw_i(size_sw_i),
      .lock_en_i(lock_en_i), .lock_sel_i(lock_sel_i));
   ims_cpu_model cpu (.clk_i(clk_i), .req_ready_i(req_ready_o),
      .req_valid_o(req_valid_i), .req_o(req_i));

   function automatic logic exp_exch(logic [1:0] k, ims_pkg::ims_ctrl_t c, logic lk);
      case (k)
         2'h1: return c.maint;
         2'h2: return !c.nodbe;
         2'h3: return !lk;
         default: return 1'b0;
      endcase
   endfunction

   task automatic chk(input string nm, input logic [63:0] e, v);
      samples_checked++;
      if (v !== e)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, v);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic wb(input logic w, input logic [31:0] a, d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rchk(input string nm, input logic [31:0] a, e);
      wb(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask

   // every mode write also clears the parity lock
   task automatic setc(input logic [4:0] v);
      wb(1'b1, 32'h0, {23'h0, 1'b1, 3'h0, v});
      ctrl  = v;
      plock = 1'b0;
   endtask

   task automatic drain;
      while (dq.size() != 0) @(posedge clk_i);
   endtask

   task automatic estep(input logic [17:0] a, input logic [31:0] st, ea);
      cpu.issue(1'b0, a, 60'h0, 1);
      drain();
      rchk("stat", 32'h4, st);
      if (ea != 0)
         rchk("eaddr", 32'h8, ea);
      wb(1'b1, 32'h4, 32'h3);
   endtask

   task automatic note(input ims_pkg::ims_req_t rq);
      logic ok_a;
      ok_a = rq.addr[17:16] < n_port;
      if (rq.we && ok_a)
      begin
         mem[rq.addr]  = rq.wdata;
         kind[rq.addr] = !ctrl.test ? 2'h0 : ctrl.par ? 2'h3 : rq.wdata[2] ? 2'h1 : 2'h2;
      end
      else if (!rq.we)
      begin
         dq.push_back(cyc_n + 2);  // launched one edge on, seen at the second
         xq.push_back(ok_a ? mem[rq.addr] : '1);
         eq.push_back(ok_a && exp_exch(kind[rq.addr], ctrl, plock));
         if (eq[$] && ctrl.par)
            plock = 1'b1;
      end
   endtask

   always @(posedge clk_i)
   begin
      cyc_n++;
      if (req_valid_i && !rst_i)
         chk("ready", !(pw && pb == req_i.addr[3:0]), req_ready_o);
      pw = req_valid_i && req_ready_o && req_i.we;
      pb = req_i.addr[3:0];
      if (req_valid_i && req_ready_o && !rst_i)
         note(req_i);
      if (dq.size() != 0 && dq[0] == cyc_n)
      begin
         chk("rsp valid", 1, rsp_valid_o);
         chk("rsp data", xq[0], rsp_data_o);
         chk("exchange", eq[0], exch_req_o);
         dq.pop_front();
         xq.pop_front();
         eq.pop_front();
      end
      else if (!rst_i)
         chk("idle rsp", 0, {rsp_valid_o, exch_req_o});
   end

   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   initial
   begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      wrap_up();
   end

   initial
   begin
      {rst_i, n_port, seed} = {1'b1, 32'd2, 32'd25};
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {67'h0, 4'hf};
      {psw_clr_i, lock_en_i, size_sw_i, lock_sel_i, ctrl, plock, pw} = '0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rchk("ctrl", 32'h0, 32'h0);
      rchk("stat", 32'h4, 32'h0);
      rchk("cfg", 32'h10, 32'h2);
      wb(1'b1, 32'h14, 32'hffff_ffff);
      rchk("unmapped", 32'h14, 32'h0);
      for (int i = 0; i < 64; i++)
         cpu.issue(1'b1, 18'(i), 60'({$random(seed), $random(seed)}), int'(i == 63));
      for (int i = 0; i < 300; i++)
      begin
         r = $random(seed);
         cpu.issue(r[8], 18'(r[5:0]), 60'({$random(seed), r}), i == 299 ? 1 : int'(r[10:9]));
      end
      cpu.issue(1'b1, 18'h20000, 60'h0, 1);
      cpu.issue(1'b0, 18'h20000, 60'h0, 1);
      drain();
      {size_sw_i, lock_en_i, lock_sel_i} <= 5'h1d;
      repeat (8) @(posedge clk_i);
      n_port = 3;
      rchk("cfg", 32'h10, 32'h1b);
      cpu.issue(1'b1, 18'h20000, 60'h5a5, 1);
      cpu.issue(1'b0, 18'h20000, 60'h0, 1);
      cpu.issue(1'b0, 18'h30000, 60'h0, 1);
      drain();
      {size_sw_i, lock_en_i, lock_sel_i} <= 5'h00;
      repeat (8) @(posedge clk_i);
      n_port = 2;
      setc(5'h04);
      cpu.issue(1'b1, 18'h40, 60'h7, 1);
      cpu.issue(1'b1, 18'h41, 60'h3, 1);
      setc(5'h05);
      cpu.issue(1'b1, 18'h42, 60'h5, 1);
      setc(5'h01);
      cpu.issue(1'b1, 18'h43, 60'h9, 1);
      estep(18'h43, 32'h0, 32'h43);
      estep(18'h42, 32'h6, 32'h42);
      estep(18'h42, 32'h4, 32'h42);
      estep(18'h43, 32'h4, 32'h42);
      setc(5'h01);
      estep(18'h42, 32'h6, 32'h42);
      setc(5'h00);
      estep(18'h40, 32'h1, 32'h40);
      setc(5'h08);
      estep(18'h40, 32'h0, 32'h0);
      setc(5'h18);
      estep(18'h41, 32'h0, 32'h0);
      setc(5'h0a);
      estep(18'h40, 32'h2, 32'h40);
      setc(5'h00);
      cpu.issue(1'b0, 18'h41, 60'h0, 1);
      drain();
      chk("psw", 1, psw_err_o);
      wb(1'b0, 32'hc, 32'h0);
      chk("syn nonzero", 1, q != 0);
      rchk("eaddr", 32'h8, 32'h41);
      psw_clr_i <= 1'b1;
      @(posedge clk_i);
      psw_clr_i <= 1'b0;
      @(posedge clk_i);
      chk("psw cleared", 0, psw_err_o);
      wrap_up();
   end
endmodule
